// ===== src/ddcr_top.sv
// Purpose: Digital datapath control register and the input datapath it steers.
// Assumes: Register port is driven by the serial control port engine on sys_clk_in.
// Assumes: Input ports and the qualifier pin are asynchronous and get synchronised here.
// Notes: Sync, filter and oscillator logic live outside; they receive the decoded fields.
`timescale 1ns/1ps
module ddcr_top (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Software reset level from the serial port configuration
    input wire logic soft_reset_in,
    // Register port from the serial control port engine
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rack_out,
    // Parallel data pins
    input wire logic [ddcr_pkg::WORD_W-1:0] first_input_port_in,
    input wire logic [ddcr_pkg::WORD_W-1:0] second_input_port_in,
    input wire logic transmit_qualifier_pin_in,
    // Assembled samples to the interpolation chain
    output logic [ddcr_pkg::WORD_W-1:0] sample_i_out,
    output logic [ddcr_pkg::WORD_W-1:0] sample_q_out,
    output logic sample_valid_out,
    // Output sample clock pin
    output logic output_sample_clock_out,
    output logic output_sample_clock_oe_n_out,
    // Decoded controls to the rest of the datapath
    output logic nco_phase_clear_out,
    output logic pn_sync_enable_out,
    output logic sync_mode_pn_out,
    output logic pulse_sync_enable_out,
    output logic inv_sinc_enable_out,
    output logic [1:0] interp_rate_out,
    output logic q_path_disable_out,
    output logic nco_gain_half_out
);

    // Convert one input word to twos complement when offset binary is selected
    function automatic logic [ddcr_pkg::WORD_W-1:0] to_twos(
        input logic [ddcr_pkg::WORD_W-1:0] word,
        input logic offset_bin
    );
        logic [ddcr_pkg::WORD_W-1:0] res;
        res = word;
        res[ddcr_pkg::WORD_W-1] = word[ddcr_pkg::WORD_W-1] ^ offset_bin;
        return res;
    endfunction

    // Register state
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;

    // Pin synchronisers
    logic [ddcr_pkg::SYNC_W-1:0] pin_meta_r;
    logic [ddcr_pkg::SYNC_W-1:0] pin_sync_r;
    logic [ddcr_pkg::SYNC_W-1:0] pin_raw;

    // Paired data from the assembler
    ddcr_pkg::ddcr_iq_s pair_w;
    logic pair_valid_w;

    // Output sample clock divider
    logic sample_clk_r;

    // Field view of the register
    ddcr_pkg::ddcr_ctrl_s ctrl;

    // Decode of the register address
    wire addr_hit = (reg_addr_in == ddcr_pkg::DDC_ADDR);
    wire wr_hit = reg_wr_in && addr_hit && !soft_reset_in;
    wire [15:0] read_word = addr_hit ? ctrl_r : 16'h0000;

    // Writes keep only defined bits; reserved bits never hold a one
    assign ctrl_nxt = reg_wdata_in & ddcr_pkg::DDC_WMASK;

    // Field extraction
    assign ctrl.phase_clear = ctrl_r[ddcr_pkg::BIT_PHASE_CLEAR];
    assign ctrl.pn_sync_en = ctrl_r[ddcr_pkg::BIT_PN_SYNC_EN];
    assign ctrl.sync_sel_pn = ctrl_r[ddcr_pkg::BIT_SYNC_SEL_PN];
    assign ctrl.pulse_sync_en = ctrl_r[ddcr_pkg::BIT_PULSE_SYNC_EN];
    assign ctrl.inv_sinc_en = ctrl_r[ddcr_pkg::BIT_INV_SINC_EN];
    assign ctrl.sample_clk_en = ctrl_r[ddcr_pkg::BIT_SAMPLE_CLK_EN];
    assign ctrl.interp = ctrl_r[ddcr_pkg::BIT_INTERP_HI:ddcr_pkg::BIT_INTERP_LO];
    assign ctrl.offset_bin = ctrl_r[ddcr_pkg::BIT_OFFSET_BIN];
    assign ctrl.single_port = ctrl_r[ddcr_pkg::BIT_SINGLE_PORT];
    assign ctrl.real_mode = ctrl_r[ddcr_pkg::BIT_REAL_MODE];
    assign ctrl.iq_invert = ctrl_r[ddcr_pkg::BIT_IQ_INVERT];
    assign ctrl.q_first = ctrl_r[ddcr_pkg::BIT_Q_FIRST];
    assign ctrl.gain_half = ctrl_r[ddcr_pkg::BIT_GAIN_HALF];

    // Control register; soft reset holds it at the power-up value while high
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= ddcr_pkg::DDC_RESET;
        end else if (soft_reset_in) begin
            ctrl_r <= ddcr_pkg::DDC_RESET;
        end else if (wr_hit) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read answer one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rack_out <= 1'b0;
        end else begin
            reg_rack_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= read_word;
            end
        end
    end

    // Gather pins into one vector so every bit passes the same two stages
    assign pin_raw = {transmit_qualifier_pin_in, second_input_port_in, first_input_port_in};

    // Two-stage synchronisers; data and qualifier stay aligned by sharing the depth
    genvar g;
    generate
        for (g = 0; g < ddcr_pkg::SYNC_W; g = g + 1) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pin_meta_r[g] <= 1'b0;
                    pin_sync_r[g] <= 1'b0;
                end else begin
                    pin_meta_r[g] <= pin_raw[g];
                    pin_sync_r[g] <= pin_meta_r[g];
                end
            end
        end
    endgenerate

    // Pair assembly for both port modes
    ddcr_pair u_pair (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(soft_reset_in),
        .single_port_in(ctrl.single_port),
        .q_first_in(ctrl.q_first),
        .iq_invert_in(ctrl.iq_invert),
        .qual_in(pin_sync_r[ddcr_pkg::SYNC_W-1]),
        .p1_in(pin_sync_r[ddcr_pkg::WORD_W-1:0]),
        .p2_in(pin_sync_r[2*ddcr_pkg::WORD_W-1:ddcr_pkg::WORD_W]),
        .pair_out(pair_w),
        .pair_valid_out(pair_valid_w)
    );

    // Format conversion and real-mode masking of the Q path
    wire [ddcr_pkg::WORD_W-1:0] conv_i = to_twos(pair_w.i, ctrl.offset_bin);
    wire [ddcr_pkg::WORD_W-1:0] conv_q = to_twos(pair_w.q, ctrl.offset_bin);
    wire [ddcr_pkg::WORD_W-1:0] gated_q = ctrl.real_mode ? ddcr_pkg::WORD_RESET : conv_q;

    // Sample outputs register the converted pair
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_i_out <= ddcr_pkg::WORD_RESET;
            sample_q_out <= ddcr_pkg::WORD_RESET;
            sample_valid_out <= 1'b0;
        end else begin
            sample_valid_out <= pair_valid_w;
            if (pair_valid_w) begin
                sample_i_out <= conv_i;
                sample_q_out <= gated_q;
            end
        end
    end

    // Output sample clock runs at half the system rate while enabled
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_clk_r <= 1'b0;
            output_sample_clock_out <= 1'b0;
            output_sample_clock_oe_n_out <= 1'b1;
        end else begin
            sample_clk_r <= ctrl.sample_clk_en ? ~sample_clk_r : 1'b0;
            output_sample_clock_out <= sample_clk_r;
            output_sample_clock_oe_n_out <= ~ctrl.sample_clk_en;
        end
    end

    // Decoded controls, registered so downstream sees clean levels
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nco_phase_clear_out <= 1'b0;
            pn_sync_enable_out <= 1'b0;
            sync_mode_pn_out <= 1'b0;
            pulse_sync_enable_out <= 1'b0;
            inv_sinc_enable_out <= 1'b0;
            interp_rate_out <= ddcr_pkg::INTERP_1X;
            q_path_disable_out <= 1'b0;
            nco_gain_half_out <= 1'b0;
        end else begin
            nco_phase_clear_out <= ctrl.phase_clear;
            pn_sync_enable_out <= ctrl.pn_sync_en;
            sync_mode_pn_out <= ctrl.sync_sel_pn;
            pulse_sync_enable_out <= ctrl.pulse_sync_en;
            inv_sinc_enable_out <= ctrl.inv_sinc_en;
            interp_rate_out <= ctrl.interp;
            q_path_disable_out <= ctrl.real_mode;
            nco_gain_half_out <= ctrl.gain_half;
        end
    end

endmodule

// ===== src/ddcr_pkg.sv
// Purpose: Shared constants and types for the digital datapath control register block.
// Assumes: Register port is the word interface of the serial control port engine.
// Notes: Every offset, field position and reset value used by the design lives here.
package ddcr_pkg;

    // Register address on the serial control port
    localparam logic [7:0] DDC_ADDR = 8'h01;

    // Field positions inside digital_datapath_control
    localparam int BIT_RSVD_HI = 15;
    localparam int BIT_PHASE_CLEAR = 14;
    localparam int BIT_PN_SYNC_EN = 13;
    localparam int BIT_SYNC_SEL_PN = 12;
    localparam int BIT_PULSE_SYNC_EN = 11;
    localparam int BIT_RSVD_LO = 10;
    localparam int BIT_INV_SINC_EN = 9;
    localparam int BIT_SAMPLE_CLK_EN = 8;
    localparam int BIT_INTERP_HI = 7;
    localparam int BIT_INTERP_LO = 6;
    localparam int BIT_OFFSET_BIN = 5;
    localparam int BIT_SINGLE_PORT = 4;
    localparam int BIT_REAL_MODE = 3;
    localparam int BIT_IQ_INVERT = 2;
    localparam int BIT_Q_FIRST = 1;
    localparam int BIT_GAIN_HALF = 0;

    // Power-up value: only the sample clock output is enabled
    localparam logic [15:0] DDC_RESET = 16'h0100;
    // Writable bits; the two reserved bits never store anything
    localparam logic [15:0] DDC_WMASK = 16'h7BFF;

    // Widths
    localparam int WORD_W = 16;
    localparam int SYNC_W = 2 * WORD_W + 1;

    // Interpolation rate codes
    localparam logic [1:0] INTERP_1X = 2'h0;
    localparam logic [1:0] INTERP_2X = 2'h1;
    localparam logic [1:0] INTERP_4X = 2'h2;
    localparam logic [1:0] INTERP_8X = 2'h3;

    // Reset values of datapath state
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 33'h000000000;

    // One assembled I/Q sample pair
    typedef struct packed {
        logic [WORD_W-1:0] i;
        logic [WORD_W-1:0] q;
    } ddcr_iq_s;

    // Decoded configuration fields
    typedef struct packed {
        logic phase_clear;
        logic pn_sync_en;
        logic sync_sel_pn;
        logic pulse_sync_en;
        logic inv_sinc_en;
        logic sample_clk_en;
        logic [1:0] interp;
        logic offset_bin;
        logic single_port;
        logic real_mode;
        logic iq_invert;
        logic q_first;
        logic gain_half;
    } ddcr_ctrl_s;

    // Pairing state of the single-port assembler
    typedef enum logic [1:0] {
        PAIR_EMPTY = 2'b01,
        PAIR_HELD = 2'b10
    } ddcr_pair_e;

endpackage

// ===== src/ddcr_pair.sv
// Purpose: Assembles I/Q pairs from the input ports in dual or single-port mode.
// Assumes: Inputs are already synchronised to sys_clk_in.
// Notes: In single-port mode a pair appears at most every second cycle.
`timescale 1ns/1ps
module ddcr_pair (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    // Configuration
    input wire logic single_port_in,
    input wire logic q_first_in,
    input wire logic iq_invert_in,
    // Synchronised port data
    input wire logic qual_in,
    input wire logic [ddcr_pkg::WORD_W-1:0] p1_in,
    input wire logic [ddcr_pkg::WORD_W-1:0] p2_in,
    // Assembled pair
    output ddcr_pkg::ddcr_iq_s pair_out,
    output logic pair_valid_out
);

    ddcr_pkg::ddcr_pair_e state_r;
    ddcr_pkg::ddcr_pair_e state_nxt;
    logic [ddcr_pkg::WORD_W-1:0] held_r;
    logic [ddcr_pkg::WORD_W-1:0] prev_q_r;
    logic have_q_r;
    ddcr_pkg::ddcr_iq_s pair_nxt;
    logic valid_nxt;

    // Qualifier meaning and which word opens a pair
    wire is_i_word = qual_in ^ iq_invert_in;
    wire lead_word = q_first_in ? ~is_i_word : is_i_word;
    wire trail_hit = ~lead_word && (state_r == ddcr_pkg::PAIR_HELD);

    // Next pair: dual port takes I from the first port and Q from the second (the previous cycle's when Q leads), single port joins two words
    always_comb begin
        state_nxt = state_r;
        pair_nxt = pair_out;
        valid_nxt = 1'b0;
        if (!single_port_in) begin
            state_nxt = ddcr_pkg::PAIR_EMPTY;
            pair_nxt.i = p1_in;
            pair_nxt.q = q_first_in ? prev_q_r : p2_in;
            valid_nxt = ~q_first_in | have_q_r;
        end else begin
            case (state_r)
                ddcr_pkg::PAIR_EMPTY: begin
                    if (lead_word) begin
                        state_nxt = ddcr_pkg::PAIR_HELD;
                    end
                end
                ddcr_pkg::PAIR_HELD: begin
                    if (trail_hit) begin
                        state_nxt = ddcr_pkg::PAIR_EMPTY;
                        pair_nxt.i = q_first_in ? p1_in : held_r;
                        pair_nxt.q = q_first_in ? held_r : p1_in;
                        valid_nxt = 1'b1;
                    end
                end
                default: begin
                    state_nxt = ddcr_pkg::PAIR_EMPTY;
                end
            endcase
        end
    end

    // Registers; a lone trailing word with nothing held is dropped
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ddcr_pkg::PAIR_EMPTY;
            held_r <= ddcr_pkg::WORD_RESET;
            prev_q_r <= ddcr_pkg::WORD_RESET;
            have_q_r <= 1'b0;
            pair_out <= '0;
            pair_valid_out <= 1'b0;
        end else if (clear_in) begin
            state_r <= ddcr_pkg::PAIR_EMPTY;
            have_q_r <= 1'b0;
            pair_valid_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (single_port_in && lead_word) begin
                held_r <= p1_in;
            end
            prev_q_r <= p2_in;
            have_q_r <= ~single_port_in;
            pair_out <= pair_nxt;
            pair_valid_out <= valid_nxt;
        end
    end

endmodule

// ===== bench/ddcr_top_monitor.sv
// Purpose: Concurrent checks on the register port and decoded outputs of ddcr_top.
// Assumes: One clock domain; a taken write shows on decoded outputs two edges later.
// Notes: Bound from the testbench top file; watches ports only.
`timescale 1ns/1ps
module ddcr_top_monitor (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic soft_reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rack_out,
    // Datapath and decoded outputs
    input wire logic sample_valid_out,
    input wire logic output_sample_clock_out,
    input wire logic output_sample_clock_oe_n_out,
    input wire logic nco_phase_clear_out,
    input wire logic pn_sync_enable_out,
    input wire logic sync_mode_pn_out,
    input wire logic pulse_sync_enable_out,
    input wire logic inv_sinc_enable_out,
    input wire logic [1:0] interp_rate_out,
    input wire logic q_path_disable_out,
    input wire logic nco_gain_half_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // A write that the register takes; soft reset blocks it
    wire logic wr_hit = reg_wr_in && (reg_addr_in == ddcr_pkg::DDC_ADDR) && !soft_reset_in;
    wire logic rd_hit = reg_rd_in && (reg_addr_in == ddcr_pkg::DDC_ADDR) && !soft_reset_in;

    // Register port timing and contents
    property p_rack; reg_rd_in |=> reg_rack_out; endproperty
    a_rack: assert property (p_rack) else $error("read answer missing");
    property p_rack_cause; reg_rack_out |-> $past(reg_rd_in); endproperty
    a_rack_cause: assert property (p_rack_cause) else $error("read answer unasked");
    property p_unmapped; reg_rd_in && reg_addr_in != ddcr_pkg::DDC_ADDR |=> reg_rdata_out == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsvd; reg_rack_out |-> !reg_rdata_out[15] && !reg_rdata_out[10]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
    property p_readback;
        wr_hit ##1 (!reg_wr_in && !soft_reset_in) ##1 rd_hit
            |=> reg_rdata_out == ($past(reg_wdata_in, 3) & ddcr_pkg::DDC_WMASK);
    endproperty
    a_readback: assert property (p_readback) else $error("read back differs");

    // Decoded fields follow the written word, or the soft reset value, two edges later
    property p_sync_fields;
        wr_hit |=> ##1 nco_phase_clear_out == $past(reg_wdata_in[14], 2)
            && pn_sync_enable_out == $past(reg_wdata_in[13], 2)
            && sync_mode_pn_out == $past(reg_wdata_in[12], 2)
            && pulse_sync_enable_out == $past(reg_wdata_in[11], 2);
    endproperty
    a_sync_fields: assert property (p_sync_fields) else $error("sync field wrong");
    property p_path_fields;
        wr_hit |=> ##1 inv_sinc_enable_out == $past(reg_wdata_in[9], 2)
            && output_sample_clock_oe_n_out == !$past(reg_wdata_in[8], 2)
            && interp_rate_out == $past(reg_wdata_in[7:6], 2)
            && q_path_disable_out == $past(reg_wdata_in[3], 2)
            && nco_gain_half_out == $past(reg_wdata_in[0], 2);
    endproperty
    a_path_fields: assert property (p_path_fields) else $error("path field wrong");
    property p_soft;
        soft_reset_in |=> ##1 interp_rate_out == 2'h0 && !inv_sinc_enable_out
            && !nco_phase_clear_out && !pn_sync_enable_out && !output_sample_clock_oe_n_out;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset value wrong");

    // Sample clock pin: quiet while released, toggling while driven
    property p_clk_off; output_sample_clock_oe_n_out [*2] |-> !output_sample_clock_out; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock runs while off");
    property p_clk_run;
        !output_sample_clock_oe_n_out [*3] |-> output_sample_clock_out != $past(output_sample_clock_out);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock not toggling");

    // Main scenarios reached
    c_read: cover property (reg_rack_out && reg_rdata_out == ddcr_pkg::DDC_RESET);
    c_soft: cover property (soft_reset_in [*3]);
    c_pair: cover property (!sample_valid_out ##1 sample_valid_out);
    c_interp: cover property (interp_rate_out == ddcr_pkg::INTERP_8X);
endmodule

// ===== bench/ddcr_src_model.sv
// Purpose: Parallel data source driving the input pins of ddcr_top.
// Assumes: cfg_in mirrors the control register; words launch 2 ns after an edge.
// Notes: Each pair it completes is noted with the cycle its sample is due.
`timescale 1ns/1ps
module ddcr_src_model (
    // Clock and register mirror
    input wire logic sys_clk_in,
    input wire logic [15:0] cfg_in,
    // Parallel data pins
    output logic [15:0] p1_out,
    output logic [15:0] p2_out,
    output logic qual_out
);
    typedef struct {
        int due;
        ddcr_pkg::ddcr_iq_s pair;
    } ddcr_note_s;
    ddcr_note_s note_q[$];
    int cyc = 0;
    logic busy = 1'b0;
    initial begin
        p1_out = 16'h0000;
        p2_out = 16'h0000;
        qual_out = 1'b0;
    end
    // Cycle count shared with the scoreboard
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
    end
    // Idle words change every cycle and are of the trailing kind, so none is held
    always @(posedge sys_clk_in) begin
        #2;
        if (!busy) begin
            p1_out = ~p1_out;
            p2_out = ~p2_out;
            qual_out = cfg_in[1] ^ cfg_in[2];
        end
    end
    // Expected pair: offset binary leaves as twos complement, real mode zeros Q
    task automatic note(input logic [15:0] i, input logic [15:0] q);
        ddcr_note_s n;
        n.due = cyc + 4; // Two sync stages, the assembler, then the output register
        n.pair.i = cfg_in[5] ? (i ^ 16'h8000) : i;
        n.pair.q = cfg_in[3] ? 16'h0000 : (cfg_in[5] ? (q ^ 16'h8000) : q);
        note_q.push_back(n);
    endtask
    // Single port: lead word then trailing word, I/Q marked by the qualifier
    task automatic send_pair(input logic [15:0] i, input logic [15:0] q);
        busy = 1'b1;
        @(posedge sys_clk_in);
        #2;
        p1_out = cfg_in[1] ? q : i;
        qual_out = !cfg_in[1] ^ cfg_in[2];
        @(posedge sys_clk_in);
        #2;
        p1_out = cfg_in[1] ? i : q;
        qual_out = cfg_in[1] ^ cfg_in[2];
        note(i, q);
        @(posedge sys_clk_in);
        busy = 1'b0;
    endtask
    // Dual port: a fresh I/Q word on each port every cycle
    task automatic stream(input int n, inout int sd);
        logic [15:0] prev;
        busy = 1'b1;
        repeat (n) begin
            @(posedge sys_clk_in);
            #2;
            prev = p2_out;
            p1_out = 16'($random(sd));
            p2_out = 16'($random(sd));
            note(p1_out, cfg_in[1] ? prev : p2_out);
        end
        @(posedge sys_clk_in);
        busy = 1'b0;
    endtask
endmodule

// ===== bench/ddcr_top_test.sv
// Purpose: Self-checking bench for ddcr_top with a data source model.
// Assumes: 20 MHz clock; inputs change 2 ns after the rising edge.
// Notes: Reads and pairs are noted in queues and checked by one watcher.
`timescale 1ns/1ps
module ddcr_top_test;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_rdata_out, first_input_port_in, second_input_port_in, sample_i_out, sample_q_out;
    logic reg_rack_out, transmit_qualifier_pin_in, sample_valid_out, output_sample_clock_out;
    logic output_sample_clock_oe_n_out, nco_phase_clear_out, pn_sync_enable_out, sync_mode_pn_out;
    logic pulse_sync_enable_out, inv_sinc_enable_out, q_path_disable_out, nco_gain_half_out;
    logic [1:0] interp_rate_out;
    logic [15:0] cfg = ddcr_pkg::DDC_RESET;
    logic [15:0] rd_q[$];
    logic [15:0] exp_rd;
    logic strict = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 31356;
    logic [15:0] modes [8] = '{16'h0100, 16'h0102, 16'h0128, 16'h0110, 16'h0114, 16'h0112,
        16'h0136, 16'h0118};

    ddcr_top dut_u (.sys_clk_in, .rst_n_in, .soft_reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .reg_rack_out, .first_input_port_in, .second_input_port_in,
        .transmit_qualifier_pin_in, .sample_i_out, .sample_q_out, .sample_valid_out,
        .output_sample_clock_out, .output_sample_clock_oe_n_out, .nco_phase_clear_out,
        .pn_sync_enable_out, .sync_mode_pn_out, .pulse_sync_enable_out, .inv_sinc_enable_out,
        .interp_rate_out, .q_path_disable_out, .nco_gain_half_out);
    ddcr_src_model src_u (.sys_clk_in, .cfg_in(cfg), .p1_out(first_input_port_in),
        .p2_out(second_input_port_in), .qual_out(transmit_qualifier_pin_in));

    always #25 sys_clk_in = ~sys_clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Register port: one strobe pulse, the mirror follows only taken writes
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        #2;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge sys_clk_in);
        #2;
        reg_wr_in = 1'b0;
        if (a == ddcr_pkg::DDC_ADDR && !soft_reset_in) cfg = d & 16'h7BFF;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge sys_clk_in);
        #2;
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        rd_q.push_back(a == ddcr_pkg::DDC_ADDR ? cfg : 16'h0000);
        @(posedge sys_clk_in);
        #2;
        reg_rd_in = 1'b0;
    endtask
    task automatic check_ctrl();
        repeat (2) @(posedge sys_clk_in);
        #2;
        check({22'h0, nco_phase_clear_out, pn_sync_enable_out, sync_mode_pn_out,
            pulse_sync_enable_out, inv_sinc_enable_out, output_sample_clock_oe_n_out,
            interp_rate_out, q_path_disable_out, nco_gain_half_out},
            {22'h0, cfg[14:11], cfg[9], ~cfg[8], cfg[7:6], cfg[3], cfg[0]});
    endtask

    // Watcher: each answer against the oldest note; an unnoted pair is a fault while strict is set
    always @(negedge sys_clk_in) begin
        if (reg_rack_out === 1'b1) begin
            exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hXXXX;
            check({16'h0000, reg_rdata_out}, {16'h0000, exp_rd});
        end
        if (src_u.note_q.size() > 0 && src_u.note_q[0].due <= src_u.cyc) begin
            check({31'h0, sample_valid_out}, 32'h1);
            check({sample_i_out, sample_q_out}, src_u.note_q[0].pair);
            void'(src_u.note_q.pop_front());
        end else if (strict && sample_valid_out !== 1'b0) begin
            check({31'h0, sample_valid_out}, 32'h0);
        end
    end

    // Main sequence: reset values, fields, refusals, soft reset, then every input mode
    initial begin
        logic [15:0] d;
        repeat (2) @(posedge sys_clk_in);
        #2;
        rst_n_in = 1'b1;
        reg_read(8'h01);
        reg_read(8'h02);
        check_ctrl();
        reg_write(8'h01, 16'hFFFF);
        reg_read(8'h01);
        for (int k = 0; k < 8; k++) begin
            d = 16'($random(seed));
            d[7:6] = k[1:0];
            d[8] = k[2]; // Half the writes turn the sample clock pin off
            reg_write(8'h01, d);
            check_ctrl();
        end
        reg_write(8'h11, 16'h5A5A);
        reg_read(8'h01);
        // Writes are refused while soft reset holds; reads still answer
        soft_reset_in = 1'b1;
        cfg = ddcr_pkg::DDC_RESET;
        reg_write(8'h01, 16'h00C5);
        reg_read(8'h01);
        soft_reset_in = 1'b0;
        check_ctrl();
        foreach (modes[m]) begin
            reg_write(8'h01, modes[m]);
            repeat (8) @(posedge sys_clk_in);
            strict = cfg[4];
            if (cfg[4]) begin
                repeat (3) src_u.send_pair(16'($random(seed)), 16'($random(seed)));
            end else begin
                src_u.stream(8, seed);
            end
            repeat (8) @(posedge sys_clk_in);
            strict = 1'b0;
        end
        give_verdict();
    end

    // Watchdog well beyond the roughly 270 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        error_cnt++;
        give_verdict();
    end
endmodule

bind ddcr_top ddcr_top_monitor mon_u (.sys_clk_in, .rst_n_in, .soft_reset_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rack_out, .sample_valid_out,
    .output_sample_clock_out, .output_sample_clock_oe_n_out, .nco_phase_clear_out,
    .pn_sync_enable_out, .sync_mode_pn_out, .pulse_sync_enable_out, .inv_sinc_enable_out,
    .interp_rate_out, .q_path_disable_out, .nco_gain_half_out);
